// ===== verification/fm_checker_assertions.sv
`timescale 1ns/1ps
module fm_checker (
    // clock, reset and handshakes
    input wire logic clk_sys_in, reset_in, clk_en_in, s_cur_tready_out,
    input wire logic s_cur_tvalid_in, s_cur_tuser_in, m_video_tready_in,
    input wire logic m_fb_tready_in, m_motion_tready_in, m_video_tvalid_out,
    input wire logic m_video_tuser_out, m_fb_tvalid_out, m_motion_tvalid_out,
    input wire logic eval_expired_out,
    // data and status
    input wire logic [15:0] m_video_tdata_out, m_fb_tdata_out,
    input wire logic [15:0] m_motion_tdata_out,
    input wire logic [31:0] framing_error_flags_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    // all three receivers ready
    wire all_rdy = m_video_tready_in & m_fb_tready_in & m_motion_tready_in;
    AST_FLAGS_STICK: assert property (
        ($past(framing_error_flags_out[3:0]) & ~framing_error_flags_out[3:0])
        == 4'h0) else $error("flag cleared");
    AST_INIT_LOW: assert property ($fell(reset_in) |->
        !s_cur_tready_out [*8]) else $error("tready high in init");
    AST_STALL_BACK: assert property (m_video_tvalid_out && !all_rdy |->
        !s_cur_tready_out) else $error("no backpressure");
    AST_OUT_HOLD: assert property (m_video_tvalid_out && !all_rdy |=>
        eval_expired_out || m_video_tvalid_out && $stable(m_video_tdata_out))
        else $error("output not held");
    AST_EXPIRED_QUIET: assert property (eval_expired_out |->
        !(m_fb_tvalid_out | m_video_tvalid_out | m_motion_tvalid_out))
        else $error("data after expiry");
    AST_EXPIRED_STAYS: assert property ($past(eval_expired_out) |->
        eval_expired_out) else $error("expiry cleared");
    AST_FB_COPY: assert property (m_video_tvalid_out |->
        m_fb_tvalid_out && m_fb_tdata_out == m_video_tdata_out &&
        m_motion_tdata_out == 16'h0) else $error("feedback mismatch");
    AST_SOF_PASS: assert property (clk_en_in && s_cur_tvalid_in &&
        s_cur_tready_out && s_cur_tuser_in |=> !m_video_tvalid_out ||
        m_video_tuser_out) else $error("frame start lost");
endmodule // fm_checker
bind video_stream_framing_monitor fm_checker chk_u (.*);

// ===== verification/fm_sink.sv
`timescale 1ns/1ps
module fm_sink (
    input wire logic clk_sys_in, stall_in,
    output logic video_ready_out = 1'h1, fb_ready_out = 1'h1,
    output logic motion_ready_out = 1'h1
);
    logic [1:0] phase_q = 2'h0;
    // each receiver stalls on its own phase while stalling is asked for
    always @(posedge clk_sys_in) begin
        phase_q <= phase_q + 2'h1;
        video_ready_out <= !(stall_in && phase_q == 2'h1);
        fb_ready_out <= !(stall_in && phase_q == 2'h2);
        motion_ready_out <= !(stall_in && phase_q == 2'h3);
    end
endmodule // fm_sink

// ===== verification/video_stream_framing_monitor_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin failures++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
module video_stream_framing_monitor_tb;
    logic clk_sys_in = 1'h0, reset_in = 1'h1, clk_en_in = 1'h1, stall = 1'h0;
    logic s_cur_tvalid_in = 1'h0, s_cur_tlast_in = 1'h0, s_cur_tuser_in = 1'h0;
    logic s_prev_tvalid_in, s_prev_tlast_in, s_prev_tuser_in, quiet = 1'h0;
    logic m_video_tready_in, m_fb_tready_in, m_motion_tready_in;
    logic s_cur_tready_out, s_prev_tready_out, eval_expired_out;
    logic m_video_tvalid_out, m_video_tlast_out, m_video_tuser_out;
    logic m_fb_tvalid_out, m_fb_tlast_out, m_fb_tuser_out;
    logic m_motion_tvalid_out, m_motion_tlast_out, m_motion_tuser_out;
    logic [15:0] s_cur_tdata_in = 16'h0, s_prev_tdata_in = 16'h0;
    logic [15:0] m_video_tdata_out, m_fb_tdata_out, m_motion_tdata_out;
    logic [12:0] active_width_in = 13'h4, active_height_in = 13'h3;
    logic [31:0] framing_error_flags_out, seed = 32'h18e85ab6;
    logic [17:0] e;
    logic [17:0] exp_q[$];
    int failures = 0, tests_run = 0, cyc = 0, lines = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    // both input streams move together
    assign {s_prev_tvalid_in, s_prev_tlast_in, s_prev_tuser_in} =
        {s_cur_tvalid_in, s_cur_tlast_in, s_cur_tuser_in};
    video_stream_framing_monitor #(.EVAL_BUILD(1'h1),
        .EVAL_TIMEOUT(64'h3e8)) dut_u (.*);
    fm_sink sink_u (.clk_sys_in(clk_sys_in), .stall_in(stall),
        .video_ready_out(m_video_tready_in), .fb_ready_out(m_fb_tready_in),
        .motion_ready_out(m_motion_tready_in));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic final_report;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one line of n beats, noting the beats that should come out
    task automatic line(input int n, input logic sof);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            if (lines >= 2 && i < 4 && !quiet)
                exp_q.push_back({sof && i == 0, i == n - 1, seed[15:0]});
            {s_cur_tvalid_in, s_cur_tlast_in, s_cur_tuser_in} <=
                {1'h1, i == n - 1, sof && i == 0};
            s_cur_tdata_in <= seed[15:0];
            s_prev_tdata_in <= ~seed[15:0];
            stall <= seed[31];
            do @(negedge clk_sys_in); while (!s_cur_tready_out);
            @(posedge clk_sys_in);
        end
        lines++;
    endtask
    // compare each accepted output beat with the oldest note
    always @(negedge clk_sys_in) begin
        if (m_video_tvalid_out && m_video_tready_in && m_fb_tready_in &&
            m_motion_tready_in) begin
            e = exp_q.size() ? exp_q.pop_front() : 18'hx;
            `CHK("beat", e, {m_video_tuser_out, m_video_tlast_out,
                m_video_tdata_out})
        end
    end
    // cut a hang short
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            final_report();
        end
    end
    // good frame, short and long lines, early and late frame starts
    initial begin
        int len[11] = '{4, 4, 4, 4, 3, 6, 4, 4, 4, 4, 4};
        logic [10:0] sof = 11'h0c9;
        repeat (12) @(posedge clk_sys_in);
        reset_in <= 1'h0;
        for (int k = 0; k < 11; k++) line(len[k], sof[k]);
        s_cur_tvalid_in <= 1'h0;
        while (exp_q.size() != 0) @(posedge clk_sys_in);
        `CHK("flags", 32'hf, framing_error_flags_out)
        `CHK("expired", 1'h0, eval_expired_out)
        // a frozen core must not offer tready to a waiting beat
        clk_en_in <= 1'h0;
        s_cur_tvalid_in <= 1'h1;
        repeat (4) @(negedge clk_sys_in);
        `CHK("frozen ready", 1'h0, s_cur_tready_out)
        @(posedge clk_sys_in);
        s_cur_tvalid_in <= 1'h0;
        clk_en_in <= 1'h1;
        while (!eval_expired_out) @(posedge clk_sys_in);
        quiet = 1'h1;
        line(4, 1'h1);
        s_cur_tvalid_in <= 1'h0;
        reset_in <= 1'h1;
        repeat (12) @(posedge clk_sys_in);
        `CHK("expired", 1'h1, eval_expired_out)
        `CHK("flags", 32'h0, framing_error_flags_out)
        final_report();
    end
endmodule // video_stream_framing_monitor_tb

// ===== verilog/framing_monitor_defines.svh
`ifndef FRAMING_MONITOR_DEFINES_SVH
`define FRAMING_MONITOR_DEFINES_SVH

// framing error flag bit positions
`define FERR_LINE_SOON_BIT 0
`define FERR_LINE_LATE_BIT 1
`define FERR_FRAME_SOON_BIT 2
`define FERR_FRAME_LATE_BIT 3
`define FERR_RESET_VALUE 32'h0000_0000
// lines suppressed on the outputs after start
`define SUPPRESS_LINES 2'h2
// initialization hold-off on input tready, in cycles
`define INIT_CYCLES 8'h10
// evaluation timeout: eight hours at 75 MHz
`define EVAL_HOURS 8
`define EVAL_REF_HZ 75000000
`define EVAL_CYCLES (64'd3600 * `EVAL_HOURS * `EVAL_REF_HZ)

`endif

// ===== verilog/framing_monitor_pkg.sv
package framing_monitor_pkg;
    typedef enum logic [0:0] {
        ST_INIT = 1'b0,
        ST_RUN = 1'b1
    } run_state_t;
endpackage

// ===== verilog/video_stream_framing_monitor.sv
`timescale 1ns/1ps
`include "framing_monitor_defines.svh"

module video_stream_framing_monitor
    import framing_monitor_pkg::*;
#(
    parameter bit EVAL_BUILD = 1'b0,
    parameter logic [63:0] EVAL_TIMEOUT = `EVAL_CYCLES
) (
    // clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    // programmed active size
    input wire logic [12:0] active_width_in,
    input wire logic [12:0] active_height_in,
    // current frame input stream
    input wire logic [15:0] s_cur_tdata_in,
    input wire logic s_cur_tvalid_in,
    input wire logic s_cur_tlast_in,
    input wire logic s_cur_tuser_in,
    output logic s_cur_tready_out,
    // previous frame input stream
    input wire logic [15:0] s_prev_tdata_in,
    input wire logic s_prev_tvalid_in,
    input wire logic s_prev_tlast_in,
    input wire logic s_prev_tuser_in,
    output logic s_prev_tready_out,
    // downstream video output
    output logic [15:0] m_video_tdata_out,
    output logic m_video_tvalid_out,
    output logic m_video_tlast_out,
    output logic m_video_tuser_out,
    input wire logic m_video_tready_in,
    // temporal feedback output
    output logic [15:0] m_fb_tdata_out,
    output logic m_fb_tvalid_out,
    output logic m_fb_tlast_out,
    output logic m_fb_tuser_out,
    input wire logic m_fb_tready_in,
    // motion data output
    output logic [15:0] m_motion_tdata_out,
    output logic m_motion_tvalid_out,
    output logic m_motion_tlast_out,
    output logic m_motion_tuser_out,
    input wire logic m_motion_tready_in,
    // status
    output logic [31:0] framing_error_flags_out,
    output logic eval_expired_out
);

    // state record, one flip-flop group for all but the evaluation counter and expiry flag
    // st: start-up hold-off or running
    // init_cnt: cycles spent in the hold-off
    // pix_cnt: accepted in-width pixels since the last line end
    // line_cnt: line ends since the last frame start
    // lines_seen: line ends since start, saturates at the suppress count
    // seen_sof: a frame start has been taken since reset
    // flags: sticky framing error bits
    // out_valid, vid, fb, last, user: the one-deep output register
    // the output register is shared by all three output streams, so a
    // beat leaves only when every receiver takes it in the same cycle;
    // this keeps the three streams in lock step without extra buffers
    typedef struct packed {
        run_state_t st;
        logic [7:0] init_cnt;
        logic [12:0] pix_cnt;
        logic [12:0] line_cnt;
        logic [1:0] lines_seen;
        logic seen_sof;
        logic [3:0] flags;
        logic out_valid;
        logic [15:0] vid;
        logic [15:0] fb;
        logic last;
        logic user;
    } state_t;

    state_t q, d;
    logic all_ready, take, in_valid, drop, line_end, sof, stall;
    // evaluation counter lives outside the reset domain
    logic [63:0] eval_cnt_q = 64'h0;
    logic expired_q = 1'b0;

    assign all_ready = m_video_tready_in & m_fb_tready_in
                     & m_motion_tready_in;
    assign stall = q.out_valid & ~all_ready;
    assign in_valid = s_cur_tvalid_in & s_prev_tvalid_in;
    // each input is ready only when its partner has a beat, so both
    // streams are taken in the same cycle; tready also drops while the
    // clock enable is low, since a frozen core cannot accept a beat
    // and a high tready would make the sender believe it was taken
    assign s_cur_tready_out = clk_en_in & (q.st == ST_RUN) & ~stall
                            & s_prev_tvalid_in;
    assign s_prev_tready_out = clk_en_in & (q.st == ST_RUN) & ~stall
                             & s_cur_tvalid_in;
    assign take = clk_en_in & in_valid & (q.st == ST_RUN) & ~stall;
    assign line_end = s_cur_tlast_in;
    assign sof = s_cur_tuser_in;
    assign drop = q.pix_cnt >= active_width_in;

    // framing checks, output register and start-up suppression
    // line checks: a line end with too few pixels sets the short flag,
    // a pixel beyond the width without a line end sets the long flag
    // and is dropped; the long-line tail, its line end included, never
    // reaches the outputs
    // frame checks: a frame start before the programmed line count sets
    // the early flag, a line end past it without a frame start sets the
    // late flag; the first frame start only arms the frame checks
    always_comb begin
        d = q;
        if (q.st == ST_INIT) begin
            d.init_cnt = q.init_cnt + 8'h01;
            if (q.init_cnt == `INIT_CYCLES)
                d.st = ST_RUN;
        end
        if (q.out_valid & all_ready)
            d.out_valid = 1'b0;
        if (take) begin
            if (sof) begin
                if (q.seen_sof && q.line_cnt < active_height_in)
                    d.flags[`FERR_FRAME_SOON_BIT] = 1'b1;
                d.line_cnt = 13'h0;
                d.seen_sof = 1'b1;
            end
            if (line_end) begin
                if (q.pix_cnt + 13'h1 < active_width_in)
                    d.flags[`FERR_LINE_SOON_BIT] = 1'b1;
                d.pix_cnt = 13'h0;
                d.line_cnt = (sof ? 13'h0 : q.line_cnt) + 13'h1;
                if (!sof && q.seen_sof && q.line_cnt >= active_height_in)
                    d.flags[`FERR_FRAME_LATE_BIT] = 1'b1;
                if (q.lines_seen != `SUPPRESS_LINES)
                    d.lines_seen = q.lines_seen + 2'h1;
            end else begin
                if (drop)
                    d.flags[`FERR_LINE_LATE_BIT] = 1'b1;
                else
                    d.pix_cnt = q.pix_cnt + 13'h1;
            end
            // forward only in-width pixels after the first two lines
            if (!drop && q.lines_seen == `SUPPRESS_LINES) begin
                d.out_valid = 1'b1;
                d.vid = s_cur_tdata_in;
                d.fb = s_cur_tdata_in;
                d.last = line_end;
                d.user = sof;
            end
        end
    end

    // state register, flags sticky until reset
    // the clock enable freezes every field, counters and flags alike
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            q <= '0;
        end else if (clk_en_in) begin
            q <= d;
        end
    end

    // evaluation timeout, not touched by reset
    // the counter starts from its power-up value and only counts up;
    // once expired it stays expired until the device is reloaded, so
    // neither the core reset nor any other input can bring video back
    // the limit is a cycle count, so the time it takes scales inversely
    // with the clock frequency
    // a non-evaluation build leaves the counter idle at zero
    always_ff @(posedge clk_sys_in) begin
        if (EVAL_BUILD && clk_en_in && !expired_q) begin
            eval_cnt_q <= eval_cnt_q + 64'h1;
            if (eval_cnt_q + 64'h1 >= EVAL_TIMEOUT)
                expired_q <= 1'b1;
        end
    end

    // stream outputs, tvalid and tdata gated by the timeout
    // tvalid and tdata are masked after expiry; tlast and tuser keep
    // their register value but carry no meaning without tvalid
    // video and feedback carry the current-frame pixel; the motion
    // stream keeps framing in step with the others and sends zero data
    always_comb begin
        m_video_tvalid_out = q.out_valid & ~expired_q;
        m_fb_tvalid_out = q.out_valid & ~expired_q;
        m_motion_tvalid_out = q.out_valid & ~expired_q;
        m_video_tdata_out = expired_q ? 16'h0 : q.vid;
        m_fb_tdata_out = expired_q ? 16'h0 : q.fb;
        m_motion_tdata_out = 16'h0; // no motion estimator in this block
        m_video_tlast_out = q.last;
        m_fb_tlast_out = q.last;
        m_motion_tlast_out = q.last;
        m_video_tuser_out = q.user;
        m_fb_tuser_out = q.user;
        m_motion_tuser_out = q.user;
        framing_error_flags_out = `FERR_RESET_VALUE | {28'h0, q.flags};
        eval_expired_out = expired_q;
    end

endmodule // video_stream_framing_monitor
